// ### hw/typec_event_mask_status.sv
// Functional notes
// - low mask bits 6 and 4..0 block their events
// - high mask bits 2,1 block force events
// - all mask bits reset to zero
// - pending bit held until master writes one
// - events latch regardless of mask
// - status bit 7 shows auto-sink active
// - status bit 6 shows bus near zero
// - status bits 5:4 report orientation
// - status bits 2:1 report sink current level
// - status bit 0 shows any attached state
// - type bit 6 debug source states
// - type bit 5 debug sink state
// - type bit 4 attached sink state
// - type bit 3 attached source state
// - type bit 2 Ra seen as source
// - type bits 1:0 audio with/without power
// - orientation event on leaving none
// - power change event on both edges
// - connect/disconnect events on partner_connected entry/exit
// - force done/failed events
`timescale 1ns/1ps
`include "typec_consts.svh"
module typec_event_mask_status
	import typec_pkg::*;
(
	input  logic        SYS_CLK,             // 10 MHz system clock
	input  logic        RST,                 // async reset, active high
	input  logic        SCL,                 // i2c clock pin
	input  logic        SDA_IN,              // i2c data pin level
	output logic        SDA_OUT,             // i2c data drive value
	output logic        SDA_OE_N,            // low while driving data pin
	output logic        INT_N,               // interrupt pin, active low
	input  conn_state_t CONN_STATE,          // connection state machine state
	input  logic        SUPPLY_ABOVE_THRESH, // supply above auto_consumer_threshold
	input  logic        AUTO_CONSUMER_EN,    // auto-sink function enable
	input  logic        BUS_POWER_NEAR_ZERO, // bus within safe zero range
	input  logic        BUS_POWER_VALID,     // bus valid indication
	input  logic [1:0]  ORIENT,              // orientation code
	input  logic [1:0]  CURRENT_LEVEL,       // cc current level code
	input  logic        RA_SEEN,             // Ra termination detected
	input  logic        SOURCE_ROLE,         // port configured as source
	input  logic        FORCE_DONE,          // forced role completed pulse
	input  logic        FORCE_FAILED         // forced role failed pulse
);
	logic [1:0] pins_sync;
	logic       scl_s;
	logic       sda_s;
	logic       scl_d;
	logic       sda_d;
	logic       start_cond;
	logic       stop_cond;
	logic       scl_rise;
	logic       scl_fall;

	i2c_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] tx;
	logic [7:0] ptr;
	logic       rw;
	logic       master_ack;
	logic       wr_en;
	logic [7:0] rd_byte;

	logic [7:0] mask_low;
	logic [7:0] mask_high;
	logic [7:0] port_status;
	logic [7:0] connection_type;
	logic [7:0] pend_low;
	logic [7:0] pend_high;
	logic [7:0] set_low;
	logic [7:0] set_high;
	logic [7:0] clr_low;
	logic [7:0] clr_high;

	logic       auto_consumer_active;
	logic       partner_connected;
	logic [1:0] advertised_current_level;
	logic       prev_valid;
	logic       prev_auto;
	logic       prev_connected;
	logic [1:0] prev_orient;
	logic [1:0] prev_level;

	sync2 #(
		.WIDTH(2)
	) u_pin_sync (
		.clk(SYS_CLK),
		.rst(RST),
		.d  ({SCL, SDA_IN}),
		.q  (pins_sync)
	);

	assign scl_s = pins_sync[1];
	assign sda_s = pins_sync[0];

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
	assign scl_rise   = scl_s & ~scl_d;
	assign scl_fall   = ~scl_s & scl_d;
	assign SDA_OUT    = 1'b0;

	// i2c slave: address, register pointer, auto-incrementing data
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			state      <= I2C_IDLE;
			bit_cnt    <= `BIT_COUNT_ZERO;
			shreg      <= `BYTE_ZERO;
			tx         <= `BYTE_ZERO;
			ptr        <= `BYTE_ZERO;
			rw         <= 1'b0;
			master_ack <= 1'b0;
			wr_en      <= 1'b0;
			SDA_OE_N   <= 1'b1;
		end else begin
			wr_en <= 1'b0;
			if (start_cond) begin
				state    <= I2C_ADDR;
				bit_cnt  <= `BIT_COUNT_ZERO;
				SDA_OE_N <= 1'b1;
			end else if (stop_cond) begin
				state    <= I2C_IDLE;
				SDA_OE_N <= 1'b1;
			end else if (scl_rise) begin
				case (state)
					I2C_ADDR, I2C_PTR, I2C_WDATA, I2C_RDATA: begin
						shreg   <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + `BIT_COUNT_STEP;
					end
					I2C_RDATA_ACK: begin
						master_ack <= ~sda_s;
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state)
					I2C_ADDR: begin
						if (bit_cnt == `BIT_COUNT_FULL) begin
							if (shreg[7:1] == `I2C_DEV_ADDR) begin
								state    <= I2C_ADDR_ACK;
								rw       <= shreg[0];
								SDA_OE_N <= 1'b0;
							end else begin
								state <= I2C_IDLE;
							end
						end
					end
					I2C_ADDR_ACK: begin
						bit_cnt <= `BIT_COUNT_ZERO;
						if (rw) begin
							state    <= I2C_RDATA;
							tx       <= rd_byte;
							SDA_OE_N <= rd_byte[7];
						end else begin
							state    <= I2C_PTR;
							SDA_OE_N <= 1'b1;
						end
					end
					I2C_PTR: begin
						if (bit_cnt == `BIT_COUNT_FULL) begin
							state    <= I2C_PTR_ACK;
							ptr      <= shreg;
							SDA_OE_N <= 1'b0;
						end
					end
					I2C_PTR_ACK, I2C_WDATA_ACK: begin
						state    <= I2C_WDATA;
						bit_cnt  <= `BIT_COUNT_ZERO;
						SDA_OE_N <= 1'b1;
						if (state == I2C_WDATA_ACK) begin
							ptr <= ptr + `PTR_STEP;
						end
					end
					I2C_WDATA: begin
						if (bit_cnt == `BIT_COUNT_FULL) begin
							state    <= I2C_WDATA_ACK;
							wr_en    <= 1'b1;
							SDA_OE_N <= 1'b0;
						end
					end
					I2C_RDATA: begin
						if (bit_cnt == `BIT_COUNT_FULL) begin
							state    <= I2C_RDATA_ACK;
							ptr      <= ptr + `PTR_STEP;
							SDA_OE_N <= 1'b1;
						end else begin
							tx       <= {tx[6:0], 1'b0};
							SDA_OE_N <= tx[6];
						end
					end
					I2C_RDATA_ACK: begin
						bit_cnt <= `BIT_COUNT_ZERO;
						if (master_ack) begin
							state    <= I2C_RDATA;
							tx       <= rd_byte;
							SDA_OE_N <= rd_byte[7];
						end else begin
							state <= I2C_IDLE;
						end
					end
					default: begin
						SDA_OE_N <= 1'b1;
					end
				endcase
			end
		end
	end

	// register read mux; unmapped addresses read zero
	always_comb begin
		case (ptr)
			`ADDR_MASK_LOW:  rd_byte = mask_low;
			`ADDR_MASK_HIGH: rd_byte = mask_high;
			`ADDR_STATUS:    rd_byte = port_status;
			`ADDR_CONN_TYPE: rd_byte = connection_type;
			`ADDR_EVT_LOW:   rd_byte = pend_low;
			`ADDR_EVT_HIGH:  rd_byte = pend_high;
			default:         rd_byte = `BYTE_ZERO;
		endcase
	end

	// mask registers; reserved bits stay zero
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			mask_low  <= `MASK_RST;
			mask_high <= `MASK_RST;
		end else if (wr_en) begin
			if (ptr == `ADDR_MASK_LOW) begin
				mask_low <= shreg & `MASK_LOW_BITS;
			end
			if (ptr == `ADDR_MASK_HIGH) begin
				mask_high <= shreg & `MASK_HIGH_BITS;
			end
		end
	end

	assign clr_low  = (wr_en && ptr == `ADDR_EVT_LOW) ? shreg : `BYTE_ZERO;
	assign clr_high = (wr_en && ptr == `ADDR_EVT_HIGH) ? shreg : `BYTE_ZERO;

	// derived port state
	assign auto_consumer_active = SUPPLY_ABOVE_THRESH | ~AUTO_CONSUMER_EN;
	assign partner_connected    = CONN_STATE != CONN_NONE;
	assign advertised_current_level = (CONN_STATE == CONN_ATT_SNK) ?
		CURRENT_LEVEL : `LEVEL_NONE;

	// read-only status bytes, refreshed every cycle
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			port_status     <= `BYTE_ZERO;
			connection_type <= `BYTE_ZERO;
		end else begin
			port_status <= {auto_consumer_active,
				BUS_POWER_NEAR_ZERO,
				ORIENT,
				BUS_POWER_VALID,
				advertised_current_level,
				partner_connected};
			connection_type <= {1'b0,
				CONN_STATE == CONN_DBG_SRC_UNOR || CONN_STATE == CONN_DBG_SRC_OR,
				CONN_STATE == CONN_DBG_SNK,
				CONN_STATE == CONN_ATT_SNK,
				CONN_STATE == CONN_ATT_SRC,
				RA_SEEN & SOURCE_ROLE,
				CONN_STATE == CONN_AUDIO && BUS_POWER_VALID,
				CONN_STATE == CONN_AUDIO && !BUS_POWER_VALID};
		end
	end

	// previous values for change detection
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			prev_valid     <= 1'b0;
			prev_auto      <= 1'b0;
			prev_connected <= 1'b0;
			prev_orient    <= `ORIENT_NONE;
			prev_level     <= `LEVEL_NONE;
		end else begin
			prev_valid     <= BUS_POWER_VALID;
			prev_auto      <= auto_consumer_active;
			prev_connected <= partner_connected;
			prev_orient    <= ORIENT;
			prev_level     <= advertised_current_level;
		end
	end

	always_comb begin
		set_low = `BYTE_ZERO;
		set_low[`B_CONNECT]    = partner_connected & ~prev_connected;
		set_low[`B_DISCONNECT] = ~partner_connected & prev_connected;
		set_low[`B_LEVEL]      = advertised_current_level != prev_level;
		set_low[`B_AUTO]       = AUTO_CONSUMER_EN & (auto_consumer_active != prev_auto);
		set_low[`B_POWER]      = BUS_POWER_VALID != prev_valid;
		set_low[`B_ORIENT]     = prev_orient == `ORIENT_NONE &&
			ORIENT != `ORIENT_NONE && ORIENT != `ORIENT_RESERVED;
		set_high = `BYTE_ZERO;
		set_high[`B_FORCE_DONE] = FORCE_DONE;
		set_high[`B_FORCE_FAIL] = FORCE_FAILED;
	end

	// pending bits latch whatever the mask says
	event_latch u_evt_low (
		.clk    (SYS_CLK),
		.rst    (RST),
		.set    (set_low),
		.clr    (clr_low),
		.impl   (`EVT_LOW_BITS),
		.pending(pend_low)
	);

	event_latch u_evt_high (
		.clk    (SYS_CLK),
		.rst    (RST),
		.set    (set_high),
		.clr    (clr_high),
		.impl   (`EVT_HIGH_BITS),
		.pending(pend_high)
	);

	// pin low while any unmasked pending bit remains
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			INT_N <= 1'b1;
		end else begin
			INT_N <= ~(|(pend_low & ~mask_low & `EVT_LOW_BITS) |
				|(pend_high & ~mask_high & `EVT_HIGH_BITS));
		end
	end
endmodule

// ### hw/typec_consts.svh
`ifndef TYPEC_CONSTS_SVH
`define TYPEC_CONSTS_SVH

`define ADDR_MASK_LOW     8'h0e
`define ADDR_MASK_HIGH    8'h0f
`define ADDR_STATUS       8'h11
`define ADDR_CONN_TYPE    8'h13
`define ADDR_EVT_LOW      8'h14
`define ADDR_EVT_HIGH     8'h15

`define MASK_RST          8'h00
`define EVT_RST           8'h00
`define BYTE_ZERO         8'h00
`define MASK_LOW_BITS     8'h7f
`define MASK_HIGH_BITS    8'h06
`define EVT_LOW_BITS      8'h5f
`define EVT_HIGH_BITS     8'h06

`define B_CONNECT         0
`define B_DISCONNECT      1
`define B_LEVEL           2
`define B_AUTO            3
`define B_POWER           4
`define B_ORIENT          6
`define B_FORCE_DONE      1
`define B_FORCE_FAIL      2

`define ORIENT_NONE       2'h0
`define ORIENT_RESERVED   2'h3
`define LEVEL_NONE        2'h0

`define I2C_DEV_ADDR      7'h22
`define BIT_COUNT_FULL    4'h8
`define BIT_COUNT_ZERO    4'h0
`define BIT_COUNT_STEP    4'h1
`define PTR_STEP          8'h01

`endif

// ### hw/typec_pkg.sv
package typec_pkg;

	typedef enum logic [2:0] {
		CONN_NONE,
		CONN_ATT_SRC,
		CONN_ATT_SNK,
		CONN_DBG_SNK,
		CONN_AUDIO,
		CONN_DBG_SRC_UNOR,
		CONN_DBG_SRC_OR
	} conn_state_t;

	typedef enum logic [3:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_ADDR_ACK,
		I2C_PTR,
		I2C_PTR_ACK,
		I2C_WDATA,
		I2C_WDATA_ACK,
		I2C_RDATA,
		I2C_RDATA_ACK
	} i2c_state_t;

endpackage

// ### hw/sync2.sv
`timescale 1ns/1ps
module sync2 #(
	parameter int WIDTH = 1
) (
	input  logic             clk,   // sampling clock
	input  logic             rst,   // async reset, active high
	input  logic [WIDTH-1:0] d,     // asynchronous input
	output logic [WIDTH-1:0] q      // synchronised output
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '1;
			q    <= '1;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// ### hw/event_latch.sv
`timescale 1ns/1ps
`include "typec_consts.svh"
module event_latch (
	input  logic       clk,      // system clock
	input  logic       rst,      // async reset, active high
	input  logic [7:0] set,      // event pulses
	input  logic [7:0] clr,      // write-one-to-clear strobes
	input  logic [7:0] impl,     // implemented bit positions
	output logic [7:0] pending   // latched events
);
	// set wins over a clear in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pending <= `EVT_RST;
		end else begin
			pending <= ((pending & ~clr) | set) & impl;
		end
	end
endmodule

// ### dv/typec_event_mask_status_sva.sv
`timescale 1ns/1ps
module typec_event_mask_status_sva
	import typec_pkg::*;
(
	input logic        SYS_CLK,         // clock
	input logic        RST,             // reset
	input logic        SCL,             // i2c clock pin
	input logic        SDA_OE_N,        // data drive enable
	input logic        INT_N,           // interrupt pin
	input conn_state_t CONN_STATE,      // connection state
	input logic        BUS_POWER_VALID, // bus valid
	input logic [1:0]  ORIENT,          // orientation code
	input logic        FORCE_DONE,      // force done pulse
	input logic        FORCE_FAILED     // force failed pulse
);
	logic       quiet;
	logic [3:0] low_cnt;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// no i2c traffic since reset, so every mask still reads zero
	always_ff @(posedge SYS_CLK or posedge RST)
		if (RST)
			quiet <= 1'b1;
		else if (!SCL)
			quiet <= 1'b0;
	always_ff @(posedge SYS_CLK or posedge RST)
		if (RST)
			low_cnt <= 4'hf;
		else if (!SCL)
			low_cnt <= 4'h0;
		else if (low_cnt != 4'hf)
			low_cnt <= low_cnt + 4'h1;
	sequence int_soon;
		##[1:6] !INT_N;
	endsequence
	property evt_int(ev);
		quiet && ev |-> int_soon;
	endproperty
	conn_int_a: assert property (evt_int(CONN_STATE != CONN_NONE &&
		$past(CONN_STATE) == CONN_NONE))
		else $error("connect gave no interrupt");
	power_int_a: assert property (evt_int($changed(BUS_POWER_VALID)))
		else $error("bus valid change gave no interrupt");
	orient_int_a: assert property (evt_int(ORIENT inside {2'h1, 2'h2} &&
		$past(ORIENT) == 2'h0))
		else $error("orientation gave no interrupt");
	done_int_a: assert property (evt_int(FORCE_DONE))
		else $error("force done gave no interrupt");
	fail_int_a: assert property (evt_int(FORCE_FAILED))
		else $error("force failed gave no interrupt");
	pend_hold_a: assert property (quiet && !INT_N |=> !INT_N)
		else $error("interrupt dropped without a write");
	int_release_a: assert property ($rose(INT_N) |-> low_cnt < 4'h8)
		else $error("interrupt released without a write");
	sda_drive_a: assert property ($fell(SDA_OE_N) |-> low_cnt < 4'h6)
		else $error("data driven outside clock low");
endmodule

bind typec_event_mask_status typec_event_mask_status_sva sva_i (.SYS_CLK, .RST, .SCL, .SDA_OE_N,
	.INT_N, .CONN_STATE, .BUS_POWER_VALID, .ORIENT, .FORCE_DONE, .FORCE_FAILED);

// ### dv/i2c_host_model.sv
`timescale 1ns/1ps
`include "typec_consts.svh"
module i2c_host_model (
	output logic scl,     // clock pin
	output logic sda_drv, // low pulls data wire
	input  logic sda      // data wire level
);
	logic nak_seen = 1'b0;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic bitx(input logic b, output logic r);
		#200 sda_drv = b;
		#200 scl = 1'b1;
		#300 r = sda;
		#100 scl = 1'b0;
	endtask
	// also serves as repeated start
	task automatic start();
		#200 sda_drv = 1'b1;
		#200 scl = 1'b1;
		#200 sda_drv = 1'b0;
		#200 scl = 1'b0;
	endtask
	task automatic stop();
		#200 sda_drv = 1'b0;
		#200 scl = 1'b1;
		#200 sda_drv = 1'b1;
		#200;
	endtask
	task automatic xfer(input logic [7:0] tx, input logic am, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bitx(tx[i], rx[i]);
		bitx(am, ack);
	endtask
	// pending bits are cleared only by the ones written here
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic       k0, k1, k2;
		start();
		xfer({`I2C_DEV_ADDR, 1'b0}, 1'b1, r, k0);
		xfer(a, 1'b1, r, k1);
		xfer(d, 1'b1, r, k2);
		stop();
		nak_seen |= k0 | k1 | k2;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] r;
		logic       k0, k1, k2, k3;
		start();
		xfer({`I2C_DEV_ADDR, 1'b0}, 1'b1, r, k0);
		xfer(a, 1'b1, r, k1);
		start();
		xfer({`I2C_DEV_ADDR, 1'b1}, 1'b1, r, k2);
		xfer(8'hff, 1'b1, d, k3);
		stop();
		nak_seen |= k0 | k1 | k2;
	endtask
endmodule

// ### dv/typec_event_mask_status_tb_top.sv
`timescale 1ns/1ps
module typec_event_mask_status_tb_top;
	import typec_pkg::*;
	logic        clk, rst, sup, en, nz, vld, ra, src, fd, ff, sdo, oe_n, int_n, scl, drv;
	logic [1:0]  ori, lvl;
	logic [7:0]  d;
	conn_state_t cs;
	int          n_mismatch = 0;
	int          checked = 0;
	int          eb[8] = '{0, 4, 6, 1, 2, 1, 2, 3};
	wire         sda = (oe_n | sdo) & drv;
	typec_event_mask_status dut (.SYS_CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda),
		.SDA_OUT(sdo), .SDA_OE_N(oe_n), .INT_N(int_n), .CONN_STATE(cs),
		.SUPPLY_ABOVE_THRESH(sup), .AUTO_CONSUMER_EN(en), .BUS_POWER_NEAR_ZERO(nz),
		.BUS_POWER_VALID(vld), .ORIENT(ori), .CURRENT_LEVEL(lvl), .RA_SEEN(ra),
		.SOURCE_ROLE(src), .FORCE_DONE(fd), .FORCE_FAILED(ff));
	i2c_host_model host (.scl(scl), .sda_drv(drv), .sda(sda));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [7:0] s, input logic [7:0] e, input string nm);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic results();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic do_rst();
		rst = 1'b1;
		cs = CONN_NONE;
		{sup, en, nz, vld, ra, src, fd, ff, ori, lvl} = '0;
		cyc(6);
		rst = 1'b0;
		cyc(4);
	endtask
	function automatic logic [7:0] exp_status();
		return {sup | !en, nz, ori, vld, cs == CONN_ATT_SNK ? lvl : 2'h0, cs != CONN_NONE};
	endfunction
	function automatic logic [7:0] exp_type();
		logic aud;
		aud = cs == CONN_AUDIO;
		return {1'b0, cs inside {CONN_DBG_SRC_UNOR, CONN_DBG_SRC_OR}, cs == CONN_DBG_SNK,
			cs == CONN_ATT_SNK, cs == CONN_ATT_SRC, ra & src, aud & vld, aud & !vld};
	endfunction
	initial begin
		#9000000;
		n_mismatch++;
		results();
	end
	initial begin
		logic [7:0] pa, m;
		void'($urandom(32'h7e62));
		do_rst();
		chk({7'h0, int_n}, 8'h01, "idle int_n");
		for (int j = 0; j < 2; j++) begin
			host.rd(8'h0e + 8'(j), d);
			chk(d, 8'h00, "mask reset");
			host.wr(8'h0e + 8'(j), 8'hff);
			host.rd(8'h0e + 8'(j), d);
			chk(d, j ? 8'h06 : 8'h7f, "mask bits");
		end
		host.rd(8'h20, d);
		chk(d, 8'h00, "unmapped");
		// one event source per pass, masked then unmasked then cleared
		for (int k = 0; k < 8; k++) begin
			do_rst();
			pa = k inside {3, 4} ? 8'h15 : 8'h14;
			m = 8'h01 << eb[k];
			// later sources start from a sink partner_connected whose connect event is cleared first
			if (k > 4) begin
				cs = CONN_ATT_SNK;
				cyc(2);
				host.wr(8'h14, 8'h01);
			end
			case (k)
				0: cs = conn_state_t'($urandom_range(1, 6));
				1: vld = 1'b1;
				2: ori = 2'($urandom_range(1, 2));
				3, 4: {fd, ff} = k == 3 ? 2'h2 : 2'h1;
				5: cs = CONN_NONE;
				6: lvl = 2'($urandom_range(1, 3));
				default: en = 1'b1;
			endcase
			cyc(1);
			{fd, ff} = '0;
			cyc(3);
			chk({7'h0, int_n}, 8'h00, "event int_n");
			host.wr(pa - 8'h06, m);
			cyc(1);
			chk({7'h0, int_n}, 8'h01, "masked int_n");
			host.rd(pa, d);
			chk(d, m, "pending");
			host.wr(pa - 8'h06, 8'h00);
			cyc(1);
			chk({7'h0, int_n}, 8'h00, "unmasked int_n");
			host.wr(pa, ~m);
			cyc(1);
			chk({7'h0, int_n}, 8'h00, "kept int_n");
			host.wr(pa, m);
			cyc(1);
			chk({7'h0, int_n}, 8'h01, "cleared int_n");
		end
		for (int i = 0; i < 14; i++) begin
			cs = conn_state_t'(i % 7);
			{sup, en, nz, vld, ra, src} = 6'($urandom);
			ori = 2'($urandom_range(0, 2));
			lvl = 2'($urandom);
			cyc(2);
			host.wr(8'h11, 8'hff);
			host.rd(8'h11, d);
			chk(d, exp_status(), "status");
			host.rd(8'h13, d);
			chk(d, exp_type(), "type");
		end
		chk({7'h0, host.nak_seen}, 8'h00, "ack");
		results();
	end
endmodule
